// ===== hw/tait_pkg.sv
package tait_pkg;

  // Interval field
  localparam int unsigned FIELD_W     = 3;
  localparam logic [2:0]  FIELD_RST   = 3'h0;

  // Elapsed monitoring-cycle counter; 2048 needs twelve bits
  localparam int unsigned ELAPSED_W   = 12;
  localparam logic [11:0] ELAPSED_RST = 12'hFFF;  // Saturated, so the first adjustment may go at once
  localparam logic [11:0] ELAPSED_MAX = 12'hFFF;

  // Shortest interval of each direction as a power of two
  localparam logic [3:0]  DEC_BASE_LOG2 = 4'h3;   // 8 cycles at code 000
  localparam logic [3:0]  INC_BASE_LOG2 = 4'h4;   // 16 cycles at code 000

  // Monitoring cycle timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MON_PER_SEC   = 8;       // Monitoring cycles per second
  localparam int unsigned MON_CLKS      = CLK_HZ / MON_PER_SEC;

  // Software write of the interval field
  typedef struct packed {
    logic       we;     // One-cycle write strobe
    logic [2:0] data;   // New field value
  } tait_field_wr_s;

  // Adjustment request from the fan control loop
  typedef struct packed {
    logic valid;        // Loop wants to move the fan start temperature
    logic increase;     // 1 = raise, 0 = lower
  } tait_adj_s;

endpackage

// ===== hw/tait_timer.sv
`timescale 1ns/100ps
module tait_timer
#(
  parameter int unsigned MON_CLKS = tait_pkg::MON_CLKS  // Clocks per monitoring cycle
)
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire tait_pkg::tait_field_wr_s field_wr_i,
  output logic [2:0]                    local_adjust_interval_o,
  output logic                          mon_tick_o,
  input  wire tait_pkg::tait_adj_s      adjust_i,
  output logic                          dec_ok_o,
  output logic                          inc_ok_o,
  output logic                          adjust_taken_o
);

  // Prescaler width; a one-clock period still needs a one-bit counter
  localparam int unsigned PW = (MON_CLKS > 1) ? $clog2(MON_CLKS) : 1;
  // Last prescaler count before the tick fires
  localparam logic [PW-1:0] PRESC_LAST = PW'(MON_CLKS - 1);

  // Interval in monitoring cycles for a code and a base exponent
  // A shift keeps this to one adder and a barrel shifter instead of a table;
  // the largest result, 2048, still fits the twelve-bit elapsed count
  // Used for both directions, hence a function rather than two copies
  function automatic logic [11:0] interval_of(input logic [2:0] code, input logic [3:0] base);
    logic [3:0] sh;
    sh = {1'b0, code} + base;
    interval_of = 12'h001 << sh;
  endfunction

  logic [PW-1:0] presc_q;          // Clock prescaler
  logic [PW-1:0] presc_d;
  logic          tick_q;           // Registered monitoring tick
  logic          tick_d;
  logic [2:0]    field_q;          // Interval field
  logic [2:0]    field_d;
  logic [11:0]   elapsed_q;        // Monitoring cycles since last adjustment
  logic [11:0]   elapsed_d;

  // Prescaler: one tick every monitoring cycle
  // The tick is registered so that the elapsed counter sees a clean pulse
  // one clock after the prescaler reaches its last count; this costs one clock of latency
  // on every interval, far below one monitoring cycle
  always_comb
  begin
    tick_d  = (presc_q == PRESC_LAST);
    presc_d = tick_d ? '0 : presc_q + PW'(1);
  end

  // Field write; the register is the read-back path as well
  // Writes are taken at any time, including mid-interval
  always_comb
  begin
    field_d = field_wr_i.we ? field_wr_i.data : field_q;
  end

  // Gates compare against the live field, so a new value counts at once
  // Limitation: shrinking the field mid-interval can open a gate early,
  // which software must allow for when it retunes the loop
  // The acceptance is combinational so the loop learns the answer in the
  // same cycle and may hold its request until a gate opens
  always_comb
  begin
    dec_ok_o       = elapsed_q >= interval_of(field_q, tait_pkg::DEC_BASE_LOG2);
    inc_ok_o       = elapsed_q >= interval_of(field_q, tait_pkg::INC_BASE_LOG2);
    adjust_taken_o = adjust_i.valid && (adjust_i.increase ? inc_ok_o : dec_ok_o);
  end

  // Elapsed counter; restart beats a coincident tick, saturates to avoid wrap
  // Without saturation a long idle loop would wrap and close both gates again
  always_comb
  begin
    if (adjust_taken_o)
    begin
      elapsed_d = '0;
    end
    else if (tick_q && elapsed_q != tait_pkg::ELAPSED_MAX)
    begin
      elapsed_d = elapsed_q + 12'h001;
    end
    else
    begin
      elapsed_d = elapsed_q;
    end
  end

  // State registers
  // Reset saturates the elapsed count, so the first adjustment is free
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      presc_q   <= '0;
      tick_q    <= 1'b0;
      field_q   <= tait_pkg::FIELD_RST;
      elapsed_q <= tait_pkg::ELAPSED_RST;
    end
    else
    begin
      presc_q   <= presc_d;
      tick_q    <= tick_d;
      field_q   <= field_d;
      elapsed_q <= elapsed_d;
    end
  end

  // Read-back and tick come straight from flip-flops
  assign local_adjust_interval_o = field_q;
  assign mon_tick_o              = tick_q;

  // Helper: clocks since the last tick, for the period check
  // One extra bit so that the count of a full period never wraps
  logic [PW:0] gap_q;              // Clocks since the last tick
  logic        seen_q;             // At least one tick since reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= tick_q ? (PW+1)'(1) : gap_q + (PW+1)'(1);
      seen_q <= seen_q | tick_q;
    end
  end

  sequence taken_s;
    adjust_taken_o;
  endsequence

  sequence restarted_s;
    elapsed_q == 12'h000;
  endsequence

  // Request steps of the loop, by direction
  sequence dec_req_s;
    adjust_i.valid && !adjust_i.increase;
  endsequence

  sequence inc_req_s;
    adjust_i.valid && adjust_i.increase;
  endsequence

  // A cycle in which nothing should move the count
  sequence idle_cycle_s;
    !adjust_taken_o && !tick_q;
  endsequence

  field_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    field_wr_i.we |=> local_adjust_interval_o == $past(field_wr_i.data))
    else $error("Interval field did not take the written value");

  hold_off_a : assert property (@(posedge clk_i) disable iff (rst_i)
    taken_s |=> restarted_s ##0 !dec_ok_o ##1 !adjust_taken_o)
    else $error("Adjustment allowed right after the previous one");

  dec_interval_a : assert property (@(posedge clk_i) disable iff (rst_i)
    dec_ok_o == (elapsed_q >= (12'h008 << field_q)))
    else $error("Decrease gate disagrees with the short interval");

  inc_interval_a : assert property (@(posedge clk_i) disable iff (rst_i)
    inc_ok_o |-> dec_ok_o && elapsed_q >= (12'h010 << field_q))
    else $error("Increase gate open before the long interval");

  tick_period_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_q && seen_q && MON_CLKS > 1) |-> $past(gap_q) == (PW+1)'(MON_CLKS - 1))
    else $error("Monitoring tick period is wrong");

  count_step_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (!adjust_taken_o && tick_q && elapsed_q != 12'hFFF) |=> elapsed_q == $past(elapsed_q) + 12'h001)
    else $error("Elapsed count did not advance on a tick");

  // A refused or absent request leaves the count alone in a cycle without a tick
  refused_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    idle_cycle_s |=> elapsed_q == $past(elapsed_q))
    else $error("Elapsed count moved without tick or acceptance");

  // A full count stays full until an adjustment restarts it
  saturate_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (elapsed_q == 12'hFFF && !adjust_taken_o) |=> elapsed_q == 12'hFFF)
    else $error("Saturated count wrapped");

  // No acceptance without a request
  no_spurious_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !adjust_i.valid |-> !adjust_taken_o)
    else $error("Adjustment accepted without a request");

  // A decrease is taken once the short interval has passed
  dec_open_a : assert property (@(posedge clk_i) disable iff (rst_i)
    dec_req_s ##0 (elapsed_q >= (12'h008 << field_q)) |-> adjust_taken_o)
    else $error("Decrease refused after the short interval");

  // A decrease is refused inside the short interval
  dec_shut_a : assert property (@(posedge clk_i) disable iff (rst_i)
    dec_req_s ##0 (elapsed_q < (12'h008 << field_q)) |-> !adjust_taken_o)
    else $error("Decrease taken inside the short interval");

  // An increase is taken once the long interval has passed
  inc_open_a : assert property (@(posedge clk_i) disable iff (rst_i)
    inc_req_s ##0 (elapsed_q >= (12'h010 << field_q)) |-> adjust_taken_o)
    else $error("Increase refused after the long interval");

  // An increase is refused inside the long interval
  inc_shut_a : assert property (@(posedge clk_i) disable iff (rst_i)
    inc_req_s ##0 (elapsed_q < (12'h010 << field_q)) |-> !adjust_taken_o)
    else $error("Increase taken inside the long interval");

  // The tick is a single-clock pulse whenever the period exceeds one clock
  tick_single_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_q && MON_CLKS > 1) |=> !tick_q)
    else $error("Monitoring tick lasted more than one clock");

  // Restart wins over a tick in the same cycle
  restart_tick_a : assert property (@(posedge clk_i) disable iff (rst_i)
    taken_s ##0 tick_q |=> restarted_s)
    else $error("Coincident tick was counted after a restart");

endmodule

// ===== tb/tait_timer_bench.sv
`timescale 1ns/100ps
module tait_timer_bench;
  logic                     clk_i;       // 50 MHz clock
  logic                     rst_i;       // Active high reset
  tait_pkg::tait_field_wr_s field_wr_i;  // Interval field write
  tait_pkg::tait_adj_s      adjust_i;    // Adjustment request
  logic [2:0]               fld_o;       // Field readback
  logic                     tick_o;      // Monitoring tick
  logic                     taken_o;     // Request accepted
  logic                     dec_o;       // Decrease gate
  logic                     inc_o;       // Increase gate
  int                       failures;    // Mismatch count
  int                       tests_run;   // Comparison count
  int                       cnt;         // Ticks since last accepted request
  int                       cyc;         // Cycles for the hang limit
  bit                       seen;        // First acceptance has no interval before it
  int                       exp_q[$];    // Expected tick counts
  int                       seed = 32'hACD2E4CA;
  logic [2:0]               junk;        // Random value overwritten at once
  // Short tick period keeps the longest interval near four thousand clocks
  tait_timer #(.MON_CLKS(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .field_wr_i(field_wr_i),
    .local_adjust_interval_o(fld_o), .mon_tick_o(tick_o), .adjust_i(adjust_i),
    .dec_ok_o(dec_o), .inc_ok_o(inc_o), .adjust_taken_o(taken_o));
  // Clock generator
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic compare(input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask
  task automatic results();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Monitor: at each acceptance after the first compare the ticks seen against the oldest note
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      results();
    end
    if (!rst_i && taken_o === 1'b1)
    begin
      if (seen)
        compare(12'(exp_q.pop_front()), 12'(cnt));
      seen = 1'b1;
      cnt = 0;
    end
    else if (!rst_i && tick_o === 1'b1)
      cnt++;
  end
  // Driver: every code in both directions, back-to-back field writes
  initial
  begin
    rst_i = 1'b1;
    field_wr_i = '0;
    adjust_i = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++)
    begin
      junk = 3'($random(seed));
      @(posedge clk_i);
      field_wr_i <= '{1'b1, junk};
      @(posedge clk_i);
      field_wr_i <= '{1'b1, 3'(i)};
      @(posedge clk_i);
      field_wr_i <= '0;
      @(posedge clk_i);
      compare(12'(i % 8), 12'(fld_o));
      compare((i == 0) ? 12'h003 : 12'h000, {10'h000, dec_o, inc_o});
      repeat ($unsigned($random(seed)) % 4) @(posedge clk_i);
      if (i > 0)
        exp_q.push_back((i >= 8 ? 16 : 8) << (i % 8));
      adjust_i <= '{1'b1, i >= 8};
      do @(posedge clk_i); while (taken_o !== 1'b1);
      adjust_i <= '0;
    end
    repeat (2) @(posedge clk_i);
    results();
  end
endmodule
